// *** core/ttr_tracker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Trip fault code tracker.
// ************************************************************
module ttr_tracker
   import ttr_pkg::*;
#(
   parameter int N_ITEMS = 4,
   parameter logic [N_ITEMS-1:0] MISF_MASK = 4'h3,
   parameter int TICK_CYC = TTR_TICK_CYC,
   parameter int ERASE_HOLD_MS = TTR_ERASE_HOLD_MS,
   parameter int ENTRY_HOLD_MS = TTR_ENTRY_HOLD_MS,
   parameter int ENTRY_WIN_MS = TTR_ENTRY_WIN_MS
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ign_pin,
   input wire logic engine_run_pin,
   input wire logic pedal_full_pin,
   input wire logic [N_ITEMS-1:0] mal_det,
   input wire logic [N_ITEMS-1:0] ok_det,
   input wire logic trip_end,
   input wire logic all_monitored,
   input wire logic pat_a_met,
   input wire logic [TTR_RPM_W-1:0] rpm,
   input wire logic [TTR_LOAD_W-1:0] load,
   input wire logic [TTR_TEMP_W-1:0] coolant,
   input wire logic [$clog2(N_ITEMS)-1:0] diag_sel,
   output logic fault_lamp,
   output logic readout_active,
   output logic [N_ITEMS-1:0] pending_fault_code,
   output logic [N_ITEMS-1:0] confirmed_fault_code,
   output logic [TTR_CNT_W-1:0] diag_time
);
   localparam int IW = $clog2(N_ITEMS);
   localparam int CW = $clog2(N_ITEMS + 1);
   localparam int TW = $clog2(ERASE_HOLD_MS + ENTRY_HOLD_MS + ENTRY_WIN_MS + 1);

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (N_ITEMS < 2 || TICK_CYC < 1 || ENTRY_WIN_MS < 1 || ERASE_HOLD_MS < 2) begin : g_bad
      $error("ttr_tracker: unsupported parameter values");
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [TTR_RPM_W-1:0] absd(input logic [TTR_RPM_W-1:0] a,
                                                 input logic [TTR_RPM_W-1:0] b);
      absd = (a > b) ? a - b : b - a;
   endfunction : absd

   // Pattern C window test against one snapshot.
   function automatic logic c_match(input logic [TTR_RPM_W-1:0] srpm,
                                    input logic [TTR_LOAD_W-1:0] sload,
                                    input logic [TTR_TEMP_W-1:0] stemp,
                                    input logic [TTR_RPM_W-1:0] crpm,
                                    input logic [TTR_LOAD_W-1:0] cload,
                                    input logic [TTR_TEMP_W-1:0] ctemp);
      logic [15:0] ld;
      ld = 16'(absd(TTR_RPM_W'(cload), TTR_RPM_W'(sload))) * 16'(TTR_LOAD_TOL_DIV);
      c_match = (absd(crpm, srpm) <= TTR_RPM_W'(TTR_RPM_TOL))
         && (ld <= 16'(sload))
         && ((ctemp < TTR_TEMP_W'(TTR_COOL_SPLIT_C)) == (stemp < TTR_TEMP_W'(TTR_COOL_SPLIT_C)));
   endfunction : c_match

   // ************************************************************
   // Pin synchronisers and millisecond tick
   // ************************************************************
   logic [2:0] ign_s_r, eng_s_r, ped_s_r;
   logic ign_q_r, eng_q_r, ped_q_r, ped_d_r;
   logic ped_rise, ped_fall, ms_tick;
   logic [$clog2(TICK_CYC+1)-1:0] tick_r;

   // A pin level is accepted once the second and third stages agree.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ign_s_r <= '0;
         eng_s_r <= '0;
         ped_s_r <= '0;
         ign_q_r <= 1'b0;
         eng_q_r <= 1'b0;
         ped_q_r <= 1'b0;
         ped_d_r <= 1'b0;
      end else begin
         ign_s_r <= {ign_s_r[1:0], ign_pin};
         eng_s_r <= {eng_s_r[1:0], engine_run_pin};
         ped_s_r <= {ped_s_r[1:0], pedal_full_pin};
         if (ign_s_r[1] == ign_s_r[2]) ign_q_r <= ign_s_r[2];
         if (eng_s_r[1] == eng_s_r[2]) eng_q_r <= eng_s_r[2];
         if (ped_s_r[1] == ped_s_r[2]) ped_q_r <= ped_s_r[2];
         ped_d_r <= ped_q_r;
      end
   end

   assign ped_rise = ped_q_r && !ped_d_r;
   assign ped_fall = !ped_q_r && ped_d_r;

   // Free running divider; all pedal timing is in millisecond steps.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) tick_r <= '0;
      else if (ms_tick) tick_r <= '0;
      else tick_r <= tick_r + 1'b1;
   end

   assign ms_tick = (tick_r == ($bits(tick_r))'(TICK_CYC - 1));

   // ************************************************************
   // Mode sequencer
   // ************************************************************
   ttr_mode_e mode_r;
   logic [2:0] press_r;
   logic [TW-1:0] tmr_r;
   logic erase_p;

   // The erase pulse fires on the last millisecond of a full hold in readout.
   assign erase_p = (mode_r == TTR_MD_READ) && ped_q_r && ms_tick
      && (tmr_r == TW'(ERASE_HOLD_MS - 1));

   // Pedal gestures switch modes; the engine must be stopped from the first stroke until the long hold begins.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= TTR_MD_NORMAL;
         press_r <= '0;
         tmr_r <= '0;
      end else if (!ign_q_r) begin
         mode_r <= TTR_MD_NORMAL;
         press_r <= '0;
         tmr_r <= '0;
      end else begin
         if (ms_tick) tmr_r <= tmr_r + TW'(1);
         unique case (mode_r)
            TTR_MD_NORMAL: begin
               tmr_r <= '0;
               press_r <= '0;
               if (ped_rise && !eng_q_r) mode_r <= TTR_MD_COUNT;
            end
            TTR_MD_COUNT: begin
               if (ped_fall) begin
                  press_r <= press_r + 3'h1;
                  if (press_r == 3'(TTR_ENTRY_PRESSES - 1)) mode_r <= TTR_MD_ARMED;
               end
               if (tmr_r >= TW'(ENTRY_WIN_MS) || eng_q_r) mode_r <= TTR_MD_NORMAL;
            end
            TTR_MD_ARMED: begin
               tmr_r <= '0;
               if (eng_q_r) mode_r <= TTR_MD_NORMAL;
               else if (ped_rise) mode_r <= TTR_MD_HOLD;
            end
            TTR_MD_HOLD: begin
               if (!ped_q_r) mode_r <= TTR_MD_NORMAL;
               else if (tmr_r >= TW'(ENTRY_HOLD_MS)) mode_r <= TTR_MD_ENTREL;
            end
            TTR_MD_ENTREL: begin
               tmr_r <= '0;
               if (!ped_q_r) mode_r <= TTR_MD_READ;
            end
            TTR_MD_READ: begin
               if (!ped_q_r) tmr_r <= '0;
               if (erase_p) mode_r <= TTR_MD_ERASED;
            end
            TTR_MD_ERASED: begin
               tmr_r <= '0;
               if (!ped_q_r) mode_r <= TTR_MD_READ;
            end
            default: mode_r <= TTR_MD_NORMAL;
         endcase
      end
   end

   // ************************************************************
   // Per-item fault memory
   // ************************************************************
   logic [N_ITEMS-1:0] pend_r, conf_r, pend_old_r, ng_trip_r, psnap_r, csnap_r;
   logic [TTR_CNT_W-1:0] a_cnt_r [N_ITEMS];
   logic [TTR_CNT_W-1:0] c_cnt_r [N_ITEMS];
   logic [TTR_RPM_W-1:0] s_rpm_r [N_ITEMS];
   logic [TTR_LOAD_W-1:0] s_load_r [N_ITEMS];
   logic [TTR_TEMP_W-1:0] s_temp_r [N_ITEMS];
   logic [N_ITEMS-1:0] conf_evt;

   // A detection confirms when the item was already pending from an earlier trip or is still confirmed.
   assign conf_evt = mal_det & (pend_old_r | conf_r);

   // Detections win over OK results and over trip-end aging in the same cycle.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pend_r <= '0;
         conf_r <= '0;
         pend_old_r <= '0;
         ng_trip_r <= '0;
         psnap_r <= '0;
         csnap_r <= '0;
         for (int i = 0; i < N_ITEMS; i++) begin
            a_cnt_r[i] <= '0;
            c_cnt_r[i] <= '0;
            s_rpm_r[i] <= '0;
            s_load_r[i] <= '0;
            s_temp_r[i] <= '0;
         end
      end else if (erase_p) begin
         pend_r <= '0;
         conf_r <= '0;
         pend_old_r <= '0;
         ng_trip_r <= '0;
         psnap_r <= '0;
         csnap_r <= '0;
         for (int i = 0; i < N_ITEMS; i++) begin
            a_cnt_r[i] <= '0;
            c_cnt_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N_ITEMS; i++) begin
            if (trip_end) begin
               ng_trip_r[i] <= 1'b0;
               pend_old_r[i] <= pend_r[i] | mal_det[i];
               if (!ng_trip_r[i] && !mal_det[i] && conf_r[i]) begin
                  if (MISF_MASK[i]) begin
                     if (c_match(s_rpm_r[i], s_load_r[i], s_temp_r[i], rpm, load, coolant)) begin
                        c_cnt_r[i] <= c_cnt_r[i] + TTR_CNT_W'(1);
                        pend_r[i] <= 1'b0;
                        if (c_cnt_r[i] == TTR_CNT_W'(TTR_C_LIMIT - 1)) begin
                           conf_r[i] <= 1'b0;
                           csnap_r[i] <= 1'b0;
                        end
                     end
                  end else if (pat_a_met) begin
                     a_cnt_r[i] <= a_cnt_r[i] + TTR_CNT_W'(1);
                     if (a_cnt_r[i] == TTR_CNT_W'(TTR_A_LIMIT - 1)) begin
                        conf_r[i] <= 1'b0;
                        csnap_r[i] <= 1'b0;
                     end
                  end
               end
            end
            if (mal_det[i]) begin
               ng_trip_r[i] <= !trip_end;
               a_cnt_r[i] <= '0;
               c_cnt_r[i] <= '0;
               if (conf_evt[i]) begin
                  conf_r[i] <= 1'b1;
                  csnap_r[i] <= 1'b1;
                  s_rpm_r[i] <= rpm;
                  s_load_r[i] <= load;
                  s_temp_r[i] <= coolant;
                  if (MISF_MASK[i]) psnap_r[i] <= 1'b0;
               end else if (!pend_r[i]) begin
                  pend_r[i] <= 1'b1;
                  psnap_r[i] <= 1'b1;
                  s_rpm_r[i] <= rpm;
                  s_load_r[i] <= load;
                  s_temp_r[i] <= coolant;
               end
            end else if (ok_det[i] && pend_r[i] && MISF_MASK[i]) begin
               pend_r[i] <= 1'b0;
            end else if (ok_det[i] && pend_r[i] && pend_old_r[i]) begin
               pend_r[i] <= 1'b0;
               psnap_r[i] <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // Lamp latch and B counter
   // ************************************************************
   logic lamp_r;
   logic [TTR_B_W-1:0] b_r;

   // Any malfunction restarts the clean-drive count; a confirmation relights the lamp.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lamp_r <= 1'b0;
         b_r <= '0;
      end else if (erase_p) begin
         lamp_r <= 1'b0;
         b_r <= '0;
      end else if (|conf_evt) begin
         lamp_r <= 1'b1;
         b_r <= '0;
      end else if (|mal_det) begin
         b_r <= '0;
      end else if (trip_end && all_monitored && !(|ng_trip_r) && lamp_r) begin
         b_r <= b_r + TTR_B_W'(1);
         if (b_r == TTR_B_W'(TTR_B_LIMIT - 1)) begin
            lamp_r <= 1'b0;
            b_r <= '0;
         end
      end
   end

   // ************************************************************
   // Code readout
   // ************************************************************
   logic [N_ITEMS-1:0] show;
   logic [IW-1:0] ptr_r, nxt_idx;
   logic nxt_ok, bl_start, bl_busy, bl_lamp, bl_abort;
   logic [CW-1:0] bl_code;

   // Both kinds of stored code are listed under the same number.
   assign show = pend_r | conf_r;

   // Round robin search for the next stored code after the last one shown.
   always_comb begin
      nxt_ok = 1'b0;
      nxt_idx = ptr_r;
      for (int k = N_ITEMS; k >= 1; k--) begin
         if (show[IW'((int'(ptr_r) + k) % N_ITEMS)]) begin
            nxt_ok = 1'b1;
            nxt_idx = IW'((int'(ptr_r) + k) % N_ITEMS);
         end
      end
   end

   assign bl_abort = (mode_r != TTR_MD_READ) && (mode_r != TTR_MD_ENTREL);
   assign bl_start = !bl_abort && !bl_busy;
   assign bl_code = nxt_ok ? CW'(nxt_idx) + CW'(1) : '0;

   // The pointer moves when a code is handed to the blinker, and returns to the last item on abort.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) ptr_r <= IW'(N_ITEMS - 1);
      else if (bl_abort) ptr_r <= IW'(N_ITEMS - 1);
      else if (bl_start && nxt_ok) ptr_r <= nxt_idx;
   end

   ttr_blinker #(
      .CW(CW)
   ) u_blink (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ms_tick(ms_tick),
      .abort(bl_abort),
      .start(bl_start),
      .code(bl_code),
      .busy(bl_busy),
      .done(),
      .lamp(bl_lamp)
   );

   // ************************************************************
   // Registered outputs
   // ************************************************************
   // The lamp blinks in readout, stays dark while an erase waits for release.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fault_lamp <= 1'b0;
         readout_active <= 1'b0;
         diag_time <= '0;
      end else begin
         readout_active <= !bl_abort;
         if (mode_r == TTR_MD_ERASED) fault_lamp <= 1'b0;
         else if (!bl_abort) fault_lamp <= bl_lamp;
         else if (ign_q_r && !eng_q_r) fault_lamp <= 1'b1;
         else if (ign_q_r) fault_lamp <= lamp_r;
         else fault_lamp <= 1'b0;
         diag_time <= MISF_MASK[diag_sel] ? c_cnt_r[diag_sel] : a_cnt_r[diag_sel];
      end
   end

   assign pending_fault_code = pend_r;
   assign confirmed_fault_code = conf_r;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_erase;
      erase_p;
   endsequence
   sequence s_empty;
      ##1 (pend_r == '0 && conf_r == '0 && !lamp_r);
   endsequence

   erase_clears_a: assert property (@(posedge sys_clk) disable iff (!rstn) s_erase |-> s_empty)
      else $error("erase left stored codes");
   zero_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (bl_start && show == '0) |-> bl_code == '0)
      else $error("empty memory not reported as zero");
   bulb_check_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ign_q_r && !eng_q_r && mode_r == TTR_MD_NORMAL) |=> fault_lamp)
      else $error("bulb check lamp dark");
   run_lamp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ign_q_r && eng_q_r && bl_abort && mode_r != TTR_MD_ERASED) |=> fault_lamp == $past(lamp_r))
      else $error("running lamp does not follow latch");
   pend_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mal_det[0] && !erase_p) |=> (pend_r[0] || conf_r[0]))
      else $error("detection not stored");
   confirm_lamp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (|(mal_det & pend_old_r) && !erase_p)
      |=> ((conf_r & $past(mal_det & pend_old_r)) == $past(mal_det & pend_old_r))
      && lamp_r && b_r == '0)
      else $error("second trip not confirmed");
   b_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (|mal_det && !erase_p) |=> b_r == '0)
      else $error("B counter not cleared");
   b_lamp_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (trip_end && all_monitored && lamp_r && b_r == TTR_B_W'(TTR_B_LIMIT - 1)
       && mal_det == '0 && ng_trip_r == '0 && !erase_p) |=> !lamp_r)
      else $error("lamp stayed on after third clean drive");
   misf_ok_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ok_det[0] && MISF_MASK[0] && !mal_det[0] && !erase_p) |=> !pend_r[0])
      else $error("misfire pending not cleared on OK");
   ign_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !ign_q_r |=> mode_r == TTR_MD_NORMAL ##1 !readout_active)
      else $error("ignition off did not return to normal");
endmodule : ttr_tracker
`default_nettype wire

// *** core/ttr_pkg.sv ***
// ************************************************************
// Shared constants of the trip fault code tracker.
// ************************************************************
package ttr_pkg;
   // System clock rate and the derived millisecond tick.
   localparam int TTR_CLK_HZ = 25_000_000;
   localparam int TTR_MS_PER_S = 1000;
   localparam int TTR_TICK_CYC = TTR_CLK_HZ / TTR_MS_PER_S;
   // Pedal timings in milliseconds and the entry press count.
   localparam int TTR_ERASE_HOLD_MS = 10_000;
   localparam int TTR_ENTRY_HOLD_MS = 10_000;
   localparam int TTR_ENTRY_WIN_MS = 5_000;
   localparam int TTR_ENTRY_PRESSES = 5;
   // Drive counter limits.
   localparam int TTR_B_LIMIT = 3;
   localparam int TTR_A_LIMIT = 40;
   localparam int TTR_C_LIMIT = 80;
   // Pattern C windows.
   localparam int TTR_RPM_TOL = 375;
   localparam int TTR_LOAD_TOL_DIV = 10;
   localparam int TTR_COOL_SPLIT_C = 70;
   // Blink waveform in milliseconds.
   localparam int TTR_BLINK_ON_MS = 300;
   localparam int TTR_BLINK_OFF_MS = 300;
   localparam int TTR_BLINK_GAP_MS = 1500;
   localparam int TTR_BLINK_ZERO_MS = 1200;
   // Field widths.
   localparam int TTR_RPM_W = 14;
   localparam int TTR_LOAD_W = 8;
   localparam int TTR_TEMP_W = 8;
   localparam int TTR_CNT_W = 7;
   localparam int TTR_B_W = 2;
   // Operating modes of the pedal and readout sequencer.
   typedef enum logic [2:0] {
      TTR_MD_NORMAL = 3'b000,
      TTR_MD_COUNT = 3'b001,
      TTR_MD_ARMED = 3'b010,
      TTR_MD_HOLD = 3'b011,
      TTR_MD_ENTREL = 3'b100,
      TTR_MD_READ = 3'b101,
      TTR_MD_ERASED = 3'b110
   } ttr_mode_e;
   // Blinker phases.
   typedef enum logic [1:0] {
      TTR_BL_IDLE = 2'b00,
      TTR_BL_ON = 2'b01,
      TTR_BL_OFF = 2'b10,
      TTR_BL_GAP = 2'b11
   } ttr_blink_e;
endpackage : ttr_pkg

// *** core/ttr_blinker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Blink sequencer: one code as a count of lamp flashes.
// ************************************************************
module ttr_blinker
   import ttr_pkg::*;
#(
   parameter int CW = 3
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ms_tick,
   input wire logic abort,
   input wire logic start,
   input wire logic [CW-1:0] code,
   output logic busy,
   output logic done,
   output logic lamp
);
   ttr_blink_e st_r;
   logic [CW-1:0] left_r;
   logic [11:0] ms_r;
   logic zero_r;

   // A code of zero is one long flash, so an empty memory is still visible.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= TTR_BL_IDLE;
         left_r <= '0;
         ms_r <= '0;
         zero_r <= 1'b0;
      end else if (abort) begin
         st_r <= TTR_BL_IDLE;
         ms_r <= '0;
      end else begin
         unique case (st_r)
            TTR_BL_IDLE: begin
               if (start) begin
                  st_r <= TTR_BL_ON;
                  left_r <= code;
                  zero_r <= (code == '0);
                  ms_r <= '0;
               end
            end
            TTR_BL_ON: begin
               if (ms_tick) begin
                  ms_r <= ms_r + 12'h001;
                  if (ms_r == 12'(zero_r ? TTR_BLINK_ZERO_MS - 1 : TTR_BLINK_ON_MS - 1)) begin
                     ms_r <= '0;
                     left_r <= zero_r ? '0 : left_r - CW'(1);
                     st_r <= (zero_r || left_r == CW'(1)) ? TTR_BL_GAP : TTR_BL_OFF;
                  end
               end
            end
            TTR_BL_OFF: begin
               if (ms_tick) begin
                  ms_r <= ms_r + 12'h001;
                  if (ms_r == 12'(TTR_BLINK_OFF_MS - 1)) begin
                     ms_r <= '0;
                     st_r <= TTR_BL_ON;
                  end
               end
            end
            TTR_BL_GAP: begin
               if (ms_tick) begin
                  ms_r <= ms_r + 12'h001;
                  if (ms_r == 12'(TTR_BLINK_GAP_MS - 1)) begin
                     ms_r <= '0;
                     st_r <= TTR_BL_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Busy is decoded from the phase register, done from the phase, the tick and the millisecond count.
   assign busy = (st_r != TTR_BL_IDLE);
   assign done = (st_r == TTR_BL_GAP) && ms_tick && (ms_r == 12'(TTR_BLINK_GAP_MS - 1));
   assign lamp = (st_r == TTR_BL_ON);
endmodule : ttr_blinker
`default_nettype wire

// *** tb/ttr_pedal_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Driver at the pedal, acting only just after a falling edge.
// ************************************************************
module ttr_pedal_model (
   input wire logic sys_clk,
   output logic pedal_full_pin
);
   // The pedal rests fully released until a stroke is asked for.
   initial pedal_full_pin = 1'b0;
   // One full press held for a whole number of cycles, then released.
   task automatic press(input int cyc);
      @(negedge sys_clk) pedal_full_pin = 1'b1;
      repeat (cyc) @(negedge sys_clk);
      pedal_full_pin = 1'b0;
   endtask : press
   // Five quick strokes well inside the window, then the long hold.
   task automatic enter_readout(input int hold_cyc);
      int i;
      for (i = 0; i < 5; i++) begin
         press(8);
         repeat (8) @(negedge sys_clk);
      end
      press(hold_cyc);
   endtask : enter_readout
endmodule : ttr_pedal_model
`default_nettype wire

// *** tb/tb_trip_fault_code_tracker.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_trip_fault_code_tracker
   import ttr_pkg::*;
;
   logic sys_clk, rstn, ign, eng, pedal, te, allm;
   logic [3:0] mal, ok, pend, conf;
   logic lamp, rd, pat_a;
   logic [13:0] rpm;
   logic [7:0] load, clt;
   logic [1:0] sel;
   logic [6:0] dt;
   int n_mismatch = 0, checked = 0, cyc = 0;
   // ************************************************************
   // Clock, reset and hang guard.
   // ************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // A hung run counts against the design rather than stalling forever.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   ttr_pedal_model u_pedal (.sys_clk(sys_clk), .pedal_full_pin(pedal));
   // Short ticks and holds keep the pedal sequences to a few hundred cycles.
   ttr_tracker #(.TICK_CYC(4), .ERASE_HOLD_MS(20), .ENTRY_HOLD_MS(20), .ENTRY_WIN_MS(40)) u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .ign_pin(ign), .engine_run_pin(eng),
      .pedal_full_pin(pedal), .mal_det(mal), .ok_det(ok), .trip_end(te),
      .all_monitored(allm), .pat_a_met(pat_a), .rpm(rpm), .load(load),
      .coolant(clt), .diag_sel(sel), .fault_lamp(lamp), .readout_active(rd),
      .pending_fault_code(pend), .confirmed_fault_code(conf), .diag_time(dt));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Pulses last exactly one cycle and are launched off the falling edge.
   task automatic pulse(input logic [3:0] m, input logic [3:0] o, input logic t);
      @(negedge sys_clk) {mal, ok, te} = {m, o, t};
      @(negedge sys_clk) {mal, ok, te} = 9'h000;
   endtask : pulse
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wt
   // Bulb check, then the lamp clears once the engine runs fault free.
   task automatic t_lamp_modes();
      ign = 1'b1;
      wt(10); chk(lamp, 1);
      eng = 1'b1;
      wt(10); chk(lamp, 0);
   endtask : t_lamp_modes
   // Two trip detection, then lamp aging through qualifying drives only.
   task automatic t_two_trip_and_b();
      pulse(4'h4, 4'h0, 0); chk(pend, 4'h4); chk(conf, 4'h0);
      pulse(4'h0, 4'h0, 1);
      pulse(4'h4, 4'h0, 0); chk(conf, 4'h4);
      wt(8); chk(lamp, 1);
      allm = 1'b1;
      pulse(4'h0, 4'h0, 1); allm = 1'b0;
      pulse(4'h0, 4'h0, 1); allm = 1'b1;
      pulse(4'h0, 4'h0, 1); pulse(4'h0, 4'h0, 1);
      wt(8); chk(lamp, 1);
      pulse(4'h0, 4'h0, 1);
      wt(8); chk(lamp, 0);
   endtask : t_two_trip_and_b
   // A misfire item drops its pending flag the moment it reports OK.
   task automatic t_misfire_ok();
      pulse(4'h1, 4'h0, 0); chk(pend[0], 1);
      pulse(4'h0, 4'h1, 0); chk(pend[0], 0);
   endtask : t_misfire_ok
   // A misfire item ages only on pattern C drives measured against its snapshot.
   task automatic t_pattern_c();
      {rpm, load, clt, sel} = {14'h0352, 8'h1E, 8'h50, 2'h1};
      pulse(4'h2, 4'h0, 0); pulse(4'h0, 4'h0, 1);
      pulse(4'h2, 4'h0, 0); chk(conf, 4'h6);
      pulse(4'h0, 4'h0, 1); wt(1); chk(dt, 8'h00);
      rpm = 14'h04CA;
      pulse(4'h0, 4'h0, 1); wt(1); chk(dt, 8'h00);
      {rpm, load, clt} = {14'h04C9, 8'h21, 8'h45};
      pulse(4'h0, 4'h0, 1); wt(1); chk(dt, 8'h00);
      clt = 8'h46;
      pulse(4'h0, 4'h0, 1); wt(1); chk(dt, 8'h01);
      chk(pend[1], 1'b0);
      pulse(4'h2, 4'h0, 0); wt(1); chk(dt, 8'h00);
   endtask : t_pattern_c
   // Second-trip OK drops a plain pending code; A and C drives expire confirmed codes.
   task automatic t_pattern_a();
      pulse(4'h0, 4'h4, 0); chk(pend[2], 1'b0);
      sel = 2'h2;
      pat_a = 1'b1;
      pulse(4'h0, 4'h0, 1); wt(1); chk(dt, 8'h01);
      repeat (38) pulse(4'h0, 4'h0, 1);
      chk(conf[2], 1'b1);
      pulse(4'h0, 4'h0, 1); chk(conf[2], 1'b0);
      repeat (40) pulse(4'h0, 4'h0, 1);
      chk(conf[1], 1'b1);
      pulse(4'h0, 4'h0, 1); chk(conf[1], 1'b0);
      pat_a = 1'b0;
   endtask : t_pattern_a
   // Readout entry, erase by long hold, code zero, ignition off.
   task automatic t_readout_erase();
      eng = 1'b0;
      pulse(4'h8, 4'h0, 0); chk(pend, 4'h8);
      wt(8);
      u_pedal.enter_readout(120);
      wt(10); chk(rd, 1);
      u_pedal.press(120);
      wt(30); chk({pend, conf}, 8'h00);
      chk(lamp, 1);
      ign = 1'b0;
      wt(8); chk(rd, 0);
   endtask : t_readout_erase
   task automatic report_and_stop();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      {rstn, ign, eng, te, allm, mal, ok} = 13'h0000;
      {pat_a, rpm, load, clt, sel} = 33'h000000000;
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      chk({pend, conf}, 8'h00);
      t_lamp_modes();
      t_two_trip_and_b();
      t_misfire_ok();
      t_pattern_c();
      t_pattern_a();
      t_readout_erase();
      report_and_stop();
   end
endmodule : tb_trip_fault_code_tracker
`default_nettype wire
